// *** hw/port_decoder.sv ***
/*
 Slot decoder: maps a port number to module slots, inverts data.
 Assumes external input lines already synchronised to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module port_decoder (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Access
   port_bus_if.decoder bus,
   // External lines, active low
   input wire logic [15:0][7:0] ext_in_n,
   output logic [31:0][7:0] ext_out_n
);
   ////////////////////////////////////////////////////////////////////////
   logic out_ok;
   logic in_ok;
   always_comb begin
      // Alternate layout: outputs 0-3 and 8-31 exist, 4-7 do not
      if (bus.config_alt) begin
         out_ok = (bus.port_num < 5'h04) || (bus.port_num > 5'h07);
         in_ok = bus.port_num < 5'h04;
      end else begin
         out_ok = bus.port_num < 5'h10;
         in_ok = bus.port_num < 5'h10;
      end
   end
   assign bus.write_hit = out_ok;
   assign bus.read_hit = in_ok;
   // Port data inverted in both directions
   // Read bus stays quiet unless a read strobe selects a fitted input
   assign bus.read_data = (in_ok && bus.read_strobe) ?
      ~ext_in_n[bus.port_num[3:0]] : 8'h00;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ext_out_n <= '1;
      end else if (bus.write_strobe && out_ok) begin
         ext_out_n[bus.port_num] <= ~bus.write_data;
      end
   end
endmodule
`default_nettype wire

// *** hw/system_io_port_map.sv ***
/*
 System port subsystem with AXI4-Lite register access.
 Assumes synchronous active-low reset and one 200 MHz clock; external
 lines are asynchronous and synchronised here.
*/
// Chosen here: register access over AXI4-Lite.
// Functional notes
// - Four I/O slots answer in and out ports 0-3, 4-7, 8-11, 12-15.
// - Alternate layout keeps slot 0 at 0-3, outputs at 16-23, 8-15, 24-31.
// - Alternate layout ignores writes to output ports 4 to 7.
// - Every port inverts data in both directions.
// - Ports 0 and 1 serve the serial link, not user connectors.
// - Status port bits give the serial, tape and punch flags.
// - Input port 2 returns the PROM programmer readback.
// - Input ports 2 and 3 are shared wired lines with the programmer.
`timescale 1ns/1ps
`default_nettype none
module system_io_port_map (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial side inputs, active low lines
   input wire logic [7:0] serial_rx_n,
   input wire logic [7:0] serial_status_n,
   // Wired-shared lines: programmer and user open collector
   input wire logic [7:0] prom_line_n,
   input wire logic [7:0] tape_line_n,
   input wire logic prom_busy,
   // User input lines for ports 4 to 15
   input wire logic [11:0][7:0] user_in_n,
   // Outputs
   output logic [31:0][7:0] port_out_n,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0][7:0] in_s1, in_s2;
   logic busy_s1, busy_s2;
   logic [15:0][7:0] in_raw;
   always_comb begin
      in_raw[0] = serial_rx_n;
      in_raw[1] = serial_status_n;
      in_raw[2] = prom_line_n;
      in_raw[3] = tape_line_n;
      in_raw[15:4] = user_in_n;
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         in_s1 <= '1;
         in_s2 <= '1;
         busy_s1 <= 1'b0;
         busy_s2 <= 1'b0;
      end else begin
         in_s1 <= in_raw;
         in_s2 <= in_s1;
         busy_s1 <= prom_busy;
         busy_s2 <= busy_s1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   port_bus_if pbus ();
   logic config_reg;
   logic [4:0] port_sel_reg;
   logic [7:0] last_out_reg;
   logic [2:0] irq_status_reg, irq_enable_reg;
   logic [31:0][7:0] out_lines;
   port_decoder u_dec (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .bus(pbus.decoder),
      .ext_in_n(in_s2),
      .ext_out_n(out_lines)
   );
   assign pbus.port_num = port_sel_reg;
   assign pbus.config_alt = config_reg;
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] aw_addr_reg;
   logic aw_held, w_held;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic do_write;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= io_port_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_reg > io_port_pkg::ADDR_LAST_OUT ||
               aw_addr_reg[1:0] != 2'h0) ? io_port_pkg::RESP_SLVERR
               : io_port_pkg::RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   logic wr_cfg, wr_sel, wr_out, wr_clr, wr_en;
   always_comb begin
      wr_cfg = 1'b0;
      wr_sel = 1'b0;
      wr_out = 1'b0;
      wr_clr = 1'b0;
      wr_en = 1'b0;
      if (!do_write || !w_strb_reg[0]) begin
         wr_cfg = 1'b0;
      end else if (aw_addr_reg == io_port_pkg::ADDR_CONFIG) begin
         wr_cfg = 1'b1;
      end else if (aw_addr_reg == io_port_pkg::ADDR_PORT_SEL) begin
         wr_sel = 1'b1;
      end else if (aw_addr_reg == io_port_pkg::ADDR_OUT_DATA) begin
         wr_out = 1'b1;
      end else if (aw_addr_reg == io_port_pkg::ADDR_IRQ_CLEAR) begin
         wr_clr = 1'b1;
      end else if (aw_addr_reg == io_port_pkg::ADDR_IRQ_ENABLE) begin
         wr_en = 1'b1;
      end
   end
   assign pbus.write_strobe = wr_out;
   assign pbus.write_data = w_data_reg[7:0];
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         config_reg <= 1'b0;
         port_sel_reg <= 5'h00;
         irq_enable_reg <= 3'h0;
         last_out_reg <= io_port_pkg::DATA_RESET;
      end else begin
         if (wr_cfg) config_reg <= w_data_reg[0];
         if (wr_sel) port_sel_reg <= w_data_reg[4:0];
         if (wr_en) irq_enable_reg <= w_data_reg[2:0];
         if (wr_out && pbus.write_hit) last_out_reg <= w_data_reg[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Events: dropped write, serial and tape data arriving
   logic rx_prev, tape_prev;
   logic [2:0] events;
   assign events[io_port_pkg::IRQ_WRITE_DROP] = wr_out && !pbus.write_hit;
   assign events[io_port_pkg::IRQ_RX_AVAIL] =
      !in_s2[1][io_port_pkg::ST_RX_AVAIL] && !rx_prev;
   assign events[io_port_pkg::IRQ_TAPE_AVAIL] =
      !in_s2[1][io_port_pkg::ST_TAPE_AVAIL] && !tape_prev;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rx_prev <= 1'b0;
         tape_prev <= 1'b0;
         irq_status_reg <= 3'h0;
         irq <= 1'b0;
      end else begin
         rx_prev <= !in_s2[1][io_port_pkg::ST_RX_AVAIL];
         tape_prev <= !in_s2[1][io_port_pkg::ST_TAPE_AVAIL];
         // Set wins over clear
         irq_status_reg <= (irq_status_reg &
            ~(wr_clr ? w_data_reg[2:0] : 3'h0)) | events;
         irq <= |(irq_status_reg & irq_enable_reg);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Programmer owns port 3 lines while busy; user data reads as idle
   logic [7:0] in_value;
   assign pbus.read_strobe = s_axi_arvalid && s_axi_arready;
   always_comb begin
      if (busy_s2 && port_sel_reg == io_port_pkg::TAPE_READER_PORT) begin
         in_value = 8'h00;
      end else begin
         in_value = pbus.read_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= io_port_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= io_port_pkg::RESP_OKAY;
            if (s_axi_araddr == io_port_pkg::ADDR_CONFIG) begin
               s_axi_rdata <= {31'h0, config_reg};
            end else if (s_axi_araddr == io_port_pkg::ADDR_PORT_SEL) begin
               s_axi_rdata <= {27'h0, port_sel_reg};
            end else if (s_axi_araddr == io_port_pkg::ADDR_IN_DATA) begin
               s_axi_rdata <= {23'h0, pbus.read_hit, in_value};
            end else if (s_axi_araddr == io_port_pkg::ADDR_IRQ_STATUS) begin
               s_axi_rdata <= {29'h0, irq_status_reg};
            end else if (s_axi_araddr == io_port_pkg::ADDR_IRQ_ENABLE) begin
               s_axi_rdata <= {29'h0, irq_enable_reg};
            end else if (s_axi_araddr == io_port_pkg::ADDR_LAST_OUT) begin
               s_axi_rdata <= {24'h0, last_out_reg};
            end else if (s_axi_araddr == io_port_pkg::ADDR_OUT_DATA ||
                  s_axi_araddr == io_port_pkg::ADDR_IRQ_CLEAR) begin
               s_axi_rdata <= 32'h00000000;
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= io_port_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         port_out_n <= '1;
      end else begin
         port_out_n <= out_lines;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   drop_alt_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      wr_out && config_reg && port_sel_reg >= 5'h04 && port_sel_reg <= 5'h07
      |=> $stable(out_lines))
      else $error("write to port 4-7 took effect in alternate layout");
   // Two edges: decoder register, then the output register
   invert_out_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      wr_out && pbus.write_hit |=> ##1
      port_out_n[$past(port_sel_reg, 2)] == ~$past(pbus.write_data, 2))
      else $error("output port not inverted data");
   four_io_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      !config_reg |-> pbus.write_hit == (port_sel_reg < 5'h10))
      else $error("four slot layout decode wrong");
   alt_map_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      config_reg |-> pbus.read_hit == (port_sel_reg < 5'h04) &&
      pbus.write_hit == (port_sel_reg < 5'h04 || port_sel_reg > 5'h07))
      else $error("alternate layout decode wrong");
   read_idle_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      !(pbus.read_hit && pbus.read_strobe) |-> pbus.read_data == 8'h00)
      else $error("read data driven without selection");
   invert_in_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      pbus.read_strobe && pbus.read_hit |->
      pbus.read_data == ~in_s2[port_sel_reg[3:0]])
      else $error("input port not inverted data");
   rx_read_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      pbus.read_strobe && port_sel_reg == io_port_pkg::SERIAL_RECEIVE_PORT
      |-> pbus.read_data == ~in_s2[0])
      else $error("serial receive port wrong");
   prom_read_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      pbus.read_strobe && port_sel_reg == io_port_pkg::PROM_READBACK_PORT
      |-> pbus.read_data == ~in_s2[2])
      else $error("prom readback port wrong");
   status_read_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      pbus.read_strobe && port_sel_reg == io_port_pkg::SERIAL_STATUS_PORT
      |-> pbus.read_data == ~in_s2[1])
      else $error("status port wrong");
   shared_busy_a: assert property (@(posedge sys_clk)
      disable iff (!nrst)
      busy_s2 && port_sel_reg == io_port_pkg::TAPE_READER_PORT |->
      in_value == 8'h00)
      else $error("shared port read during programming");
   irq_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      |(irq_status_reg & irq_enable_reg) |=> irq)
      else $error("interrupt not raised");
   irq_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (irq_status_reg & irq_enable_reg) == 3'h0 |=> !irq)
      else $error("interrupt raised without enabled status");
   // Set beats clear when both land in one cycle
   set_wins_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      events != 3'h0 |=>
      (irq_status_reg & $past(events)) == $past(events))
      else $error("status event lost");
   write_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      s_axi_bvalid && s_axi_bready);
   read_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      s_axi_rvalid && s_axi_rready);
   drop_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      events[io_port_pkg::IRQ_WRITE_DROP]);
   busy_read_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      busy_s2 && pbus.read_strobe &&
      port_sel_reg == io_port_pkg::TAPE_READER_PORT);
   alt_write_c: cover property (@(posedge sys_clk) disable iff (!nrst)
      wr_out && config_reg && pbus.write_hit);
endmodule
`default_nettype wire

// *** shared/io_port_pkg.sv ***
/*
 Port map package: port numbers, register offsets, status bit positions.
 Assumes a single 200 MHz system clock domain.
*/
package io_port_pkg;
   localparam int DATA_W = 8;
   localparam int PORT_W = 5;
   // Input port numbers
   localparam logic [4:0] SERIAL_RECEIVE_PORT = 5'h00;
   localparam logic [4:0] SERIAL_STATUS_PORT = 5'h01;
   localparam logic [4:0] PROM_READBACK_PORT = 5'h02;
   localparam logic [4:0] TAPE_READER_PORT = 5'h03;
   // Status bit positions
   localparam int ST_RX_AVAIL = 0;
   localparam int ST_OVERRUN = 1;
   localparam int ST_TX_EMPTY = 2;
   localparam int ST_FRAMING = 3;
   localparam int ST_PARITY = 4;
   localparam int ST_TAPE_AVAIL = 5;
   localparam int ST_PUNCH_READY = 6;
   // AXI register byte addresses
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_PORT_SEL = 8'h04;
   localparam logic [7:0] ADDR_OUT_DATA = 8'h08;
   localparam logic [7:0] ADDR_IN_DATA = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] ADDR_LAST_OUT = 8'h1C;
   // Interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_WRITE_DROP = 0;
   localparam int IRQ_RX_AVAIL = 1;
   localparam int IRQ_TAPE_AVAIL = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] DATA_RESET = 8'h00;
   typedef enum logic {CFG_FOUR_IO, CFG_ONE_IO_THREE_OUT} config_t;
endpackage

// *** shared/port_bus_if.sv ***
/*
 Port access carrier between the register front end and the port decoder.
 Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface port_bus_if;
   logic [4:0] port_num;
   logic write_strobe;
   logic read_strobe;
   logic [7:0] write_data;
   logic [7:0] read_data;
   logic read_hit;
   logic write_hit;
   logic config_alt;
   modport front (output port_num, write_strobe, read_strobe, write_data,
      config_alt, input read_data, read_hit, write_hit);
   modport decoder (input port_num, write_strobe, read_strobe, write_data,
      config_alt, output read_data, read_hit, write_hit);
endinterface
`default_nettype wire

// *** verif/ext_peripheral_model.sv ***
/*
 External equipment model: serial unit, programmer and tape reader lines.
 Assumes values arrive as processor-side data; every line is active low.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_peripheral_model (
   // Processor-side values
   input wire logic [7:0] rx_val,
   input wire logic [7:0] stat_val,
   input wire logic [7:0] prog_val,
   input wire logic [7:0] tape_val,
   input wire logic [11:0][7:0] user_val,
   input wire logic prom_busy,
   // Active-low lines
   output logic [7:0] serial_rx_n,
   output logic [7:0] serial_status_n,
   output logic [7:0] prom_line_n,
   output logic [7:0] tape_line_n,
   output logic [11:0][7:0] user_in_n
);
   assign serial_rx_n = ~rx_val;
   assign serial_status_n = ~stat_val;
   assign prom_line_n = ~prog_val;
   assign user_in_n = ~user_val;
   // Released open collector floats to the pull-up level
   assign tape_line_n = prom_busy ? 8'hFF : ~tape_val;
endmodule
`default_nettype wire

// *** verif/system_io_port_map_tb.sv ***
/*
 Self-checking bench for the port subsystem over AXI4-Lite.
 Assumes a 200 MHz clock and the external model on the line side.
*/
`timescale 1ns/1ps
`default_nettype none
module system_io_port_map_tb;
   logic sys_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, prom_busy, irq, cfg;
   logic [7:0] s_axi_awaddr, s_axi_araddr, serial_rx_n, serial_status_n;
   logic [7:0] prom_line_n, tape_line_n, rx_val, stat_val, prog_val;
   logic [7:0] tape_val, lst;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [11:0][7:0] user_in_n, user_val;
   logic [31:0][7:0] port_out_n, om;
   logic [2:0] sts, en;
   int fails, comparisons;

   system_io_port_map system_io_port_map_inst (.sys_clk, .nrst,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .serial_rx_n, .serial_status_n, .prom_line_n,
      .tape_line_n, .prom_busy, .user_in_n, .port_out_n, .irq);
   ext_peripheral_model ext_peripheral_model_inst (.rx_val, .stat_val,
      .prog_val, .tape_val, .user_val, .prom_busy, .serial_rx_n,
      .serial_status_n, .prom_line_n, .tape_line_n, .user_in_n);

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [255:0] s, input logic [255:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // Every handshake wait is bounded so a hang ends the run
   task bump(inout int n);
      n++;
      if (n > 100) begin
         fails++;
         stop_test();
      end
   endtask
   // Xorshift step on the shared seed
   function void rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   // Ready lines stay high, so a response is always taken at once
   task axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         bump(n);
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
   endtask
   task axr(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         bump(n);
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask

   ////////////////////////////////////////////////////////////////////
   task do_reset;
      rx_val <= 8'h00;
      stat_val <= 8'h00;
      nrst <= 1'b0;
      cyc(12);
      nrst <= 1'b1;
      om = '1;
      sts = '0;
      en = '0;
      cfg = 1'b0;
      lst = io_port_pkg::DATA_RESET;
      cyc(1);
      chk(port_out_n, om);
      chk(irq, 1'b0);
      axr(io_port_pkg::ADDR_CONFIG);
      chk(rd, 32'h0);
      axr(io_port_pkg::ADDR_IRQ_STATUS);
      chk(rd, 32'h0);
   endtask
   task put_out(input int p, input logic [7:0] d);
      logic ok;
      ok = cfg ? (p < 4 || p > 7) : (p < 16);
      axw(io_port_pkg::ADDR_PORT_SEL, 32'(p));
      axw(io_port_pkg::ADDR_OUT_DATA, {24'h0, d});
      chk(rsp, io_port_pkg::RESP_OKAY);
      if (ok) begin
         om[p] = ~d;
         lst = d;
      end else begin
         sts[io_port_pkg::IRQ_WRITE_DROP] = 1'b1;
      end
      cyc(3);
      chk(port_out_n, om);
      chk(irq, |(sts & en));
      // Dropped writes must leave the last accepted byte alone
      axr(io_port_pkg::ADDR_LAST_OUT);
      chk(rd, {24'h0, lst});
   endtask
   task get_in(input int p);
      logic [7:0] v;
      logic hit;
      hit = cfg ? p < 4 : p < 16;
      v = p == 0 ? rx_val : p == 1 ? stat_val : p == 2 ? prog_val :
         p == 3 ? (prom_busy ? 8'h00 : tape_val) : user_val[(p - 4) % 12];
      if (!hit) v = 8'h00;
      axw(io_port_pkg::ADDR_PORT_SEL, 32'(p));
      axr(io_port_pkg::ADDR_IN_DATA);
      chk(rsp, io_port_pkg::RESP_OKAY);
      if (prom_busy && p == 3) chk(rd, {23'h0, hit, 8'h00});
      else chk(rd, {23'h0, hit, v});
   endtask
   task set_lines(input logic busy);
      rnd();
      if (seed[0] && !stat_val[0]) sts[io_port_pkg::IRQ_RX_AVAIL] = 1'b1;
      if (seed[5] && !stat_val[5]) sts[io_port_pkg::IRQ_TAPE_AVAIL] = 1'b1;
      stat_val <= seed[7:0];
      rx_val <= seed[15:8];
      prog_val <= seed[23:16];
      tape_val <= seed[31:24];
      for (int i = 0; i < 12; i++) begin
         rnd();
         user_val[i] <= seed[7:0];
      end
      prom_busy <= busy;
      cyc(6);
      chk(irq, |(sts & en));
   endtask
   task run_cfg;
      axw(io_port_pkg::ADDR_IRQ_ENABLE, 32'h7);
      en = 3'h7;
      axr(io_port_pkg::ADDR_IRQ_ENABLE);
      chk(rd, {29'h0, en});
      for (int p = 0; p < 32; p++) begin
         rnd();
         put_out(p, seed[7:0]);
      end
      axr(io_port_pkg::ADDR_IRQ_STATUS);
      chk(rd, {29'h0, sts});
      axw(io_port_pkg::ADDR_IRQ_CLEAR, 32'h7);
      sts = '0;
      cyc(2);
      chk(irq, 1'b0);
      for (int b = 0; b < 2; b++) begin
         set_lines(b[0]);
         for (int p = 0; p < 32; p++) get_in(p);
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      comparisons = 0;
      seed = 32'hAC0218E4;
      nrst = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      s_axi_wstrb = 4'hF;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      prom_busy = 1'b0;
      {rx_val, stat_val, prog_val, tape_val} = 32'h0;
      user_val = '0;
      do_reset();
      run_cfg();
      // Masked event stays silent until its enable is set
      axw(io_port_pkg::ADDR_IRQ_ENABLE, 32'h2);
      en = 3'h2;
      stat_val <= 8'h00;
      prom_busy <= 1'b0;
      cyc(6);
      axw(io_port_pkg::ADDR_IRQ_CLEAR, 32'h7);
      sts = '0;
      stat_val <= 8'h21;
      cyc(6);
      sts = 3'h6;
      chk(irq, 1'b1);
      axr(io_port_pkg::ADDR_IRQ_STATUS);
      chk(rd, 32'h6);
      axw(io_port_pkg::ADDR_IRQ_CLEAR, 32'h2);
      cyc(2);
      chk(irq, 1'b0);
      axw(io_port_pkg::ADDR_IRQ_ENABLE, 32'h4);
      cyc(2);
      chk(irq, 1'b1);
      // Unmapped and unaligned accesses are refused without effect
      axw(8'h20, 32'h1);
      chk(rsp, io_port_pkg::RESP_SLVERR);
      axw(8'h05, 32'h1);
      chk(rsp, io_port_pkg::RESP_SLVERR);
      axr(8'h20);
      chk(rsp, io_port_pkg::RESP_SLVERR);
      chk(rd, 32'h0);
      chk(port_out_n, om);
      // Byte lane 0 unselected: answered, but nothing lands
      s_axi_wstrb <= 4'hE;
      axw(io_port_pkg::ADDR_CONFIG, 32'h1);
      chk(rsp, io_port_pkg::RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axr(io_port_pkg::ADDR_CONFIG);
      chk(rd, 32'h0);
      do_reset();
      axw(io_port_pkg::ADDR_CONFIG, 32'h1);
      cfg = 1'b1;
      axr(io_port_pkg::ADDR_CONFIG);
      chk(rd, 32'h1);
      run_cfg();
      stop_test();
   end
endmodule
`default_nettype wire
